/* File: rtl/rsc_cmd_decode.sv */
// Run-time settings command decoder: ADC reference, edge interrupt, pin zero
// ------------------------------------------------------------
// Function
// RULE_01: Byte 5 bit 7 set loads byte 5 bits 2-0 as the ADC reference, else it is kept.
// RULE_02: Byte 5 bits 2-1 give the reference module level 4.096, 2.048, 1.024 V or off.
// RULE_03: Byte 5 bit 0 picks the internal reference module (1) or the supply rail (0).
// RULE_04: Byte 6 changes edge settings and flag only when its bit 7 is set.
// RULE_05: Byte 6 bit 3 replaces the rising-edge enable only when byte 6 bit 4 is set.
// RULE_06: A set rising-edge enable makes rising input edges trigger, else they do not.
// RULE_07: Byte 6 bit 1 replaces the falling-edge enable only when byte 6 bit 2 is set.
// RULE_08: A set falling-edge enable makes falling input edges trigger, else they do not.
// RULE_09: Byte 6 bit 0 set, with byte 6 enabled, clears the detection flag.
// RULE_10: Byte 7 bit 7 set loads pin zero settings from byte 8, else they are kept.
// RULE_11: Pin zero as a general-purpose output drives the level of byte 8 bit 4.
// RULE_12: Byte 8 bit 3 sets pin zero direction, 1 input, 0 output, in general-purpose role.
// RULE_13: Byte 8 bits 2-0 pick general-purpose, suspend or receive LED; codes 3-7 are ignored.
// RULE_14: Only a report whose byte 0 is 0x60 is taken as a settings update.
// RULE_15: Loaded settings are volatile and return to reset values on every reset.
// RULE_16: An enabled input edge sets the detection flag, which holds until cleared.
// RULE_17: Don't-care bits of bytes 5, 6 and 8 have no effect on stored settings.
// ------------------------------------------------------------
`timescale 1ns/100ps
module rsc_cmd_decode (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic cmd_valid,
	input wire logic [8*rsc_pkg::CMD_BYTES-1:0] cmd_data,
	input wire logic irq_sense,
	input wire logic suspend_indicator,
	input wire logic receive_activity_led,
	input wire logic pin_zero_i,
	output logic [1:0] adc_vrm_level,
	output logic adc_ref_from_vrm,
	output logic irq_rise_en,
	output logic irq_fall_en,
	output logic irq_flag,
	output logic [2:0] pin_zero_role,
	output logic pin_zero_dir,
	output logic pin_zero_o,
	output logic pin_zero_oe,
	output logic pin_zero_in_level
);
	rsc_pkg::rsc_state_t s_q;
	rsc_pkg::rsc_state_t s_d;
	logic [7:0] b0;
	logic [7:0] b5;
	logic [7:0] b6;
	logic [7:0] b7;
	logic [7:0] b8;
	logic take;
	logic adc_ld;
	logic irq_ld;
	logic pin_ld;
	logic clr;
	logic role_ok;

	rsc_edge_if edge_bus ();

	rsc_edge_det u_edge (
		.clk(clk),
		.arst_n(arst_n),
		.sense_in(irq_sense),
		.edge_bus(edge_bus)
	);

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	assign b0 = cmd_data[7:0];
	assign b5 = cmd_data[8*rsc_pkg::BYTE_ADC +: 8];
	assign b6 = cmd_data[8*rsc_pkg::BYTE_IRQ +: 8];
	assign b7 = cmd_data[8*rsc_pkg::BYTE_PIN_EN +: 8];
	assign b8 = cmd_data[8*rsc_pkg::BYTE_PIN0 +: 8];
	assign take = cmd_valid && (b0 == rsc_pkg::CMD_SET_RUNTIME); // see RULE_14
	assign adc_ld = take && b5[rsc_pkg::LOAD_BIT]; // see RULE_01
	assign irq_ld = take && b6[rsc_pkg::LOAD_BIT]; // see RULE_04
	assign pin_ld = take && b7[rsc_pkg::LOAD_BIT]; // see RULE_10
	assign clr = irq_ld && b6[rsc_pkg::FLAG_CLR_BIT]; // see RULE_09
	// Reserved designations leave the whole pin setting untouched
	assign role_ok = b8[rsc_pkg::PIN_ROLE_HI:0] <= rsc_pkg::ROLE_RX_LED; // see RULE_13

	assign edge_bus.rise_en = s_q.rise_en;
	assign edge_bus.fall_en = s_q.fall_en;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		if (adc_ld)
			s_d.adc_ref = b5[rsc_pkg::ADC_SEL_HI:0]; // see RULE_01, see RULE_17
		if (irq_ld && b6[rsc_pkg::RISE_MOD_BIT])
			s_d.rise_en = b6[rsc_pkg::RISE_VAL_BIT]; // see RULE_05
		if (irq_ld && b6[rsc_pkg::FALL_MOD_BIT])
			s_d.fall_en = b6[rsc_pkg::FALL_VAL_BIT]; // see RULE_07
		// An edge in the clearing cycle still counts: set beats clear
		s_d.flag = (s_q.flag && !clr) || edge_bus.hit; // see RULE_16
		if (pin_ld && role_ok)
		begin
			s_d.role = b8[rsc_pkg::PIN_ROLE_HI:0]; // see RULE_13
			s_d.dir = b8[rsc_pkg::PIN_DIR_BIT]; // see RULE_12
			s_d.val = b8[rsc_pkg::PIN_VAL_BIT]; // see RULE_11
		end
		case (s_d.role)
			rsc_pkg::ROLE_SUSPEND:
			begin
				s_d.pin_o = suspend_indicator;
				s_d.pin_oe = 1'b1;
			end
			rsc_pkg::ROLE_RX_LED:
			begin
				s_d.pin_o = receive_activity_led;
				s_d.pin_oe = 1'b1;
			end
			default:
			begin
				s_d.pin_o = s_d.val; // see RULE_11
				s_d.pin_oe = (s_d.dir != rsc_pkg::DIR_INPUT); // see RULE_12
			end
		endcase
		s_d.pin_in = (s_q.role == rsc_pkg::ROLE_GPIO) && pin_zero_i;
	end

	// Volatile only: every reset restores the power-up values
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0; // see RULE_15
			s_q.adc_ref <= rsc_pkg::RST_ADC_REF;
			s_q.rise_en <= rsc_pkg::RST_RISE_EN;
			s_q.fall_en <= rsc_pkg::RST_FALL_EN;
			s_q.role <= rsc_pkg::RST_ROLE;
			s_q.dir <= rsc_pkg::RST_DIR;
			s_q.val <= rsc_pkg::RST_VAL;
		end
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign adc_vrm_level = s_q.adc_ref[rsc_pkg::ADC_LVL_HI:rsc_pkg::ADC_LVL_LO]; // see RULE_02
	assign adc_ref_from_vrm = s_q.adc_ref[rsc_pkg::ADC_SRC_BIT]; // see RULE_03
	assign irq_rise_en = s_q.rise_en;
	assign irq_fall_en = s_q.fall_en;
	assign irq_flag = s_q.flag;
	assign pin_zero_role = s_q.role;
	assign pin_zero_dir = s_q.dir;
	assign pin_zero_o = s_q.pin_o;
	assign pin_zero_oe = s_q.pin_oe;
	assign pin_zero_in_level = s_q.pin_in;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_adc_load;
		adc_ld |=> adc_vrm_level == $past(b5[2:1]) && adc_ref_from_vrm == $past(b5[0]);
	endproperty
	a_adc_load: assert property (p_adc_load) // see RULE_01
		else $error("ADC reference not loaded");

	property p_adc_hold;
		!adc_ld |=> $stable(s_q.adc_ref);
	endproperty
	a_adc_hold: assert property (p_adc_hold) // see RULE_01
		else $error("ADC reference changed without load");

	property p_foreign_code;
		(cmd_valid && b0 != rsc_pkg::CMD_SET_RUNTIME && !edge_bus.hit)
			|=> $stable(s_q[13:4]) && (irq_flag || !$past(irq_flag));
	endproperty
	a_foreign_code: assert property (p_foreign_code) // see RULE_14
		else $error("setting changed by other command code");

	property p_irq_gate;
		!irq_ld |=> $stable(irq_rise_en) && $stable(irq_fall_en) && (irq_flag || !$past(irq_flag));
	endproperty
	a_irq_gate: assert property (p_irq_gate) // see RULE_04
		else $error("edge settings changed without enable");

	property p_rise_load;
		(irq_ld && b6[4]) |=> irq_rise_en == $past(b6[3]);
	endproperty
	a_rise_load: assert property (p_rise_load) // see RULE_05
		else $error("rising enable not loaded");

	property p_fall_load;
		(irq_ld && b6[2]) |=> irq_fall_en == $past(b6[1]);
	endproperty
	a_fall_load: assert property (p_fall_load) // see RULE_07
		else $error("falling enable not loaded");

	property p_flag_set;
		edge_bus.hit |=> irq_flag [*2] or (irq_flag ##1 $past(clr));
	endproperty
	a_flag_set: assert property (p_flag_set) // see RULE_16
		else $error("flag not set by enabled edge");

	property p_flag_clear;
		(clr && !edge_bus.hit) |=> !irq_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) // see RULE_09
		else $error("flag not cleared");

	property p_pin_drive;
		(pin_ld && b8[2:0] == 3'h0 && !b8[3]) |=> pin_zero_oe && pin_zero_o == $past(b8[4]);
	endproperty
	a_pin_drive: assert property (p_pin_drive) // see RULE_11
		else $error("pin zero output level wrong");

	property p_role_ignore;
		(pin_ld && b8[2:0] > 3'h2) |=> $stable(pin_zero_role) && $stable(pin_zero_dir);
	endproperty
	a_role_ignore: assert property (p_role_ignore) // see RULE_13
		else $error("reserved designation accepted");

	c_adc_load: cover property (adc_ld);
	c_flag_cycle: cover property (edge_bus.hit ##[1:20] clr);
	c_pin_led: cover property (pin_ld && b8[2:0] == 3'h2);
endmodule

/* File: rtl/rsc_pkg.sv */
// Constants and types shared by the run-time settings decoder
package rsc_pkg;
	// ------------------------------------------------------------
	// Command framing
	// ------------------------------------------------------------
	localparam int CMD_BYTES = 9;
	localparam logic [7:0] CMD_SET_RUNTIME = 8'h60;
	localparam int BYTE_ADC = 5;
	localparam int BYTE_IRQ = 6;
	localparam int BYTE_PIN_EN = 7;
	localparam int BYTE_PIN0 = 8;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int LOAD_BIT = 7;
	localparam int ADC_SEL_HI = 2;
	localparam int ADC_LVL_HI = 2;
	localparam int ADC_LVL_LO = 1;
	localparam int ADC_SRC_BIT = 0;
	localparam int RISE_MOD_BIT = 4;
	localparam int RISE_VAL_BIT = 3;
	localparam int FALL_MOD_BIT = 2;
	localparam int FALL_VAL_BIT = 1;
	localparam int FLAG_CLR_BIT = 0;
	localparam int PIN_VAL_BIT = 4;
	localparam int PIN_DIR_BIT = 3;
	localparam int PIN_ROLE_HI = 2;
	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [1:0] VRM_OFF = 2'h0;
	localparam logic [1:0] VRM_1V024 = 2'h1;
	localparam logic [1:0] VRM_2V048 = 2'h2;
	localparam logic [1:0] VRM_4V096 = 2'h3;
	localparam logic [2:0] ROLE_GPIO = 3'h0;
	localparam logic [2:0] ROLE_SUSPEND = 3'h1;
	localparam logic [2:0] ROLE_RX_LED = 3'h2;
	localparam logic DIR_INPUT = 1'b1;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [2:0] RST_ADC_REF = 3'h0;
	localparam logic RST_RISE_EN = 1'b0;
	localparam logic RST_FALL_EN = 1'b0;
	localparam logic [2:0] RST_ROLE = 3'h0;
	localparam logic RST_DIR = 1'b1;
	localparam logic RST_VAL = 1'b0;
	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] adc_ref;
		logic rise_en;
		logic fall_en;
		logic flag;
		logic [2:0] role;
		logic dir;
		logic val;
		logic pin_o;
		logic pin_oe;
		logic pin_in;
	} rsc_state_t;
	typedef struct packed {
		logic prev;
		logic primed;
	} rsc_edge_state_t;
endpackage

/* File: rtl/rsc_edge_if.sv */
// Edge detector enables and hit between decoder and detector
`timescale 1ns/100ps
interface rsc_edge_if;
	logic rise_en;
	logic fall_en;
	logic hit;
	modport det (input rise_en, input fall_en, output hit);
	modport ctl (output rise_en, output fall_en, input hit);
endinterface

/* File: rtl/rsc_edge_det.sv */
// Edge detector for the external interrupt input
`timescale 1ns/100ps
module rsc_edge_det (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic sense_in,
	rsc_edge_if.det edge_bus
);
	rsc_pkg::rsc_edge_state_t s_q;
	rsc_pkg::rsc_edge_state_t s_d;

	// ------------------------------------------------------------
	// Edge qualification
	// ------------------------------------------------------------
	// First cycle after reset only learns the level, so a high input is no edge
	assign edge_bus.hit = s_q.primed & ((edge_bus.rise_en & sense_in & ~s_q.prev) // see RULE_06
		| (edge_bus.fall_en & ~sense_in & s_q.prev)); // see RULE_08

	always_comb
	begin
		s_d = s_q;
		s_d.prev = sense_in;
		s_d.primed = 1'b1;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_no_rise_when_off;
		@(posedge clk) disable iff (!arst_n)
		(!edge_bus.rise_en && sense_in && !s_q.prev) |-> !edge_bus.hit;
	endproperty
	a_no_rise_when_off: assert property (p_no_rise_when_off) // see RULE_06
		else $error("rise edge hit while disabled");
endmodule

/* File: test/rsc_host_model.sv */
// Host side model that sends fixed-length settings reports
`timescale 1ns/100ps
module rsc_host_model (
	input wire logic clk,
	output logic cmd_valid,
	output logic [8*rsc_pkg::CMD_BYTES-1:0] cmd_data
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_data = '0;
	end
	// A foreign code is only sent when the bench asks for it
	task send(input logic [7:0] code, input logic [8*rsc_pkg::CMD_BYTES-1:0] rep);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_data <= {rep[8*rsc_pkg::CMD_BYTES-1:8], code};
	endtask
	// Released data flips each idle, so every second idle in a row shows the stale report again
	task idle();
		@(posedge clk);
		cmd_valid <= 1'b0;
		cmd_data <= ~cmd_data;
	endtask
endmodule

/* File: test/rsc_cmd_decode_test.sv */
// Self-checking bench for the run-time settings decoder
`timescale 1ns/100ps
module rsc_cmd_decode_test;
	logic clk, arst_n, irq_sense, suspend_indicator, receive_activity_led, pin_zero_i;
	logic cmd_valid;
	logic [8*rsc_pkg::CMD_BYTES-1:0] cmd_data;
	logic [1:0] adc_vrm_level;
	logic adc_ref_from_vrm, irq_rise_en, irq_fall_en, irq_flag, pin_zero_dir;
	logic [2:0] pin_zero_role, m_adc, m_role;
	logic pin_zero_o, pin_zero_oe, pin_zero_in_level;
	logic m_rise, m_fall, m_flag, m_dir, m_val, m_o, m_oe, m_inl, m_prev, m_primed, hit, acc;
	logic [7:0] b5, b6, b7, b8;
	int err_count = 0;
	int n_tests = 0;
	int seed = 32'h44468332;
	logic [31:0] r;
	rsc_host_model i_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_data(cmd_data));
	rsc_cmd_decode i_dut (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data), .irq_sense(irq_sense), .suspend_indicator(suspend_indicator),
		.receive_activity_led(receive_activity_led), .pin_zero_i(pin_zero_i),
		.adc_vrm_level(adc_vrm_level), .adc_ref_from_vrm(adc_ref_from_vrm),
		.irq_rise_en(irq_rise_en), .irq_fall_en(irq_fall_en), .irq_flag(irq_flag),
		.pin_zero_role(pin_zero_role), .pin_zero_dir(pin_zero_dir), .pin_zero_o(pin_zero_o),
		.pin_zero_oe(pin_zero_oe), .pin_zero_in_level(pin_zero_in_level));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			{m_adc, m_rise, m_fall, m_flag, m_role, m_val, m_o, m_oe, m_inl} = '0;
			m_dir = 1'b1;
			m_primed = 1'b0;
		end
		else
		begin
			{b8, b7, b6, b5} = cmd_data[71:40];
			acc = cmd_valid && cmd_data[7:0] == 8'h60;
			hit = m_primed && ((m_rise && !m_prev && irq_sense) || (m_fall && m_prev && !irq_sense));
			if (acc && b5[7]) m_adc = b5[2:0];
			if (acc && b6[7] && b6[0]) m_flag = 1'b0;
			if (hit) m_flag = 1'b1;
			if (acc && b6[7] && b6[4]) m_rise = b6[3];
			if (acc && b6[7] && b6[2]) m_fall = b6[1];
			// Pin input level follows the designation held before this edge
			m_inl = m_role == 3'h0 && pin_zero_i;
			if (acc && b7[7] && b8[2:0] <= 3'h2) {m_val, m_dir, m_role} = b8[4:0];
			m_oe = m_role != 3'h0 || !m_dir;
			m_o = m_role == 3'h0 ? m_val : m_role == 3'h1 ? suspend_indicator
				: receive_activity_led;
			m_prev = irq_sense;
			m_primed = 1'b1;
		end
	end
	task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	always @(negedge clk)
	begin
		chk("adc_vrm_level", m_adc[2:1], adc_vrm_level);
		chk("adc_ref_from_vrm", m_adc[0], adc_ref_from_vrm);
		chk("irq_rise_en", m_rise, irq_rise_en);
		chk("irq_fall_en", m_fall, irq_fall_en);
		chk("irq_flag", m_flag, irq_flag);
		chk("pin_zero_role", m_role, pin_zero_role);
		chk("pin_zero_dir", m_dir, pin_zero_dir);
		chk("pin_zero_o", m_o, pin_zero_o);
		chk("pin_zero_oe", m_oe, pin_zero_oe);
		chk("pin_zero_in_level", m_inl, pin_zero_in_level);
	end
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	// Random reports carry random don't-care bits, so their effect shows up too
	task step(input bit send);
		logic [95:0] rep;
		r = $random(seed);
		rep = {$random(seed), $random(seed), $random(seed)};
		if (send)
			i_host.send(r[1:0] == 2'h0 ? r[15:8] : 8'h60, rep[71:0]);
		else
			i_host.idle();
		irq_sense <= r[16];
		suspend_indicator <= r[17];
		receive_activity_led <= r[18];
		pin_zero_i <= r[19];
	endtask
	task end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		arst_n = 1'b0;
		{irq_sense, suspend_indicator, receive_activity_led, pin_zero_i} = '0;
		repeat (20) step(1'b0);
		arst_n <= 1'b1;
		i_host.send(8'h60, {8'h10, 8'h80, 8'h98, 8'h87, 40'h0});
		i_host.send(8'h60, {8'h0B, 8'h80, 8'h86, 8'h03, 40'h0});
		step(1'b0);
		$display("directed loads done");
		repeat (3000) step(r[20] | r[21]);
		$display("random traffic done");
		// Reports still arrive in reset, but none stands at the release edge
		arst_n <= 1'b0;
		step(1'b1);
		repeat (2) step(1'b0);
		arst_n <= 1'b1;
		repeat (500) step(1'b1);
		$display("reset in mid-run done");
		end_of_test();
	end
	// Whole run is some 3526 cycles
	initial
	begin
		repeat (10000) @(posedge clk);
		err_count++;
		end_of_test();
	end
endmodule
